// ==== hdl/feat_ctl_decoder.sv ====
// Feature control command decoder with write cache control
module feat_ctl_decoder
    import feat_ctl_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,             // 100 MHz clock
    input  wire logic        nrst,            // Power-on reset, sync, active low
    input  wire logic        hard_reset,      // Hard reset pulse from transport
    // Key sector request
    input  wire logic        cmd_valid,       // Key sector ready, one-cycle pulse
    input  wire logic [15:0] key_action,      // Word 0
    input  wire logic [15:0] key_function,    // Word 1
    input  wire logic [15:0] key_feature,     // Word 2
    input  wire logic [15:0] key_state,       // Word 3
    input  wire logic [15:0] key_options,     // Word 4
    // Taskfile answer
    output logic             cmd_done,        // Answer valid, one-cycle pulse
    output logic [7:0]       tf_error,        // Error register
    output logic [7:0]       tf_sec_count,    // Sector count register
    output logic [7:0]       tf_sec_number,   // Sector number register
    output logic [7:0]       tf_status,       // Status register
    // SET FEATURES write cache request
    input  wire logic        setf_valid,      // Request pulse
    input  wire logic        setf_enable,     // 1 enable, 0 disable
    output logic             setf_done,       // Completion pulse, never errors
    // Non-volatile store
    input  wire logic        nv_restore,      // Load persisted state pulse
    input  wire logic [15:0] nv_restore_state,// Persisted state from media
    output logic             nv_save,         // Persist request pulse
    output logic [15:0]      nv_save_state,   // State to persist
    // Cache state
    output logic             cache_enable,    // Actual write cache enable
    output logic [15:0]      id_word85_mask,  // Identify word 85, cache bit only
    output logic [15:0]      wc_state_out     // Current feature state
);

    // ************************************************************
    // State
    // ************************************************************
    logic [15:0] wc_state;          // Active feature state
    logic [15:0] next_wc_state;
    logic [15:0] pers_state;        // Last persistent state
    logic [15:0] next_pers_state;
    logic        setf_wce;          // SET FEATURES cache request
    logic        next_setf_wce;
    logic        cache_on;          // Resolved enable

    logic        next_cmd_done;
    logic [7:0]  next_tf_error;
    logic [7:0]  next_tf_sec_count;
    logic [7:0]  next_tf_sec_number;
    logic [7:0]  next_tf_status;
    logic        next_setf_done;
    logic        next_nv_save;
    logic [15:0] next_nv_save_state;
    logic        next_cache_enable;

    // ************************************************************
    // Helpers
    // ************************************************************

    // Legal write cache state
    // Anything else is refused on a set and dropped on a restore
    function automatic logic wc_state_ok(input logic [15:0] s);
        wc_state_ok = (s == WC_BY_SETF) || (s == WC_FORCE_ON) || (s == WC_FORCE_OFF);
    endfunction

    // ************************************************************
    // Policy
    // ************************************************************
    // Combinational resolver, its output is registered below
    wc_policy u_policy (
        .wc_state (wc_state),
        .setf_wce (setf_wce),
        .cache_on (cache_on)
    );

    // ************************************************************
    // Next state
    // ************************************************************

    // Decode key sector, SET FEATURES, resets and restores
    // Priority for the feature state, lowest first:
    //   media restore, hard reset, then a key sector set.
    // A set that lands with a hard reset wins, so the host
    // never sees an accepted command silently undone.
    // SET FEATURES touches only its own enable bit and
    // therefore never competes with the other sources.
    always_comb begin
        // Hold all state unless an event below moves it
        next_wc_state      = wc_state;
        next_pers_state    = pers_state;
        next_setf_wce      = setf_wce;
        // Pulses fall back after one cycle, answers hold
        next_cmd_done      = 1'b0;
        next_tf_error      = tf_error;
        next_tf_sec_count  = tf_sec_count;
        next_tf_sec_number = tf_sec_number;
        next_tf_status     = tf_status;
        next_setf_done     = 1'b0;
        next_nv_save       = 1'b0;
        next_nv_save_state = nv_save_state;
        // Cache follows the resolver one stage late
        next_cache_enable  = cache_on;

        // Persisted state loaded from media
        // Illegal codes from the media are dropped, so a corrupt
        // copy cannot wedge the cache in an undefined mode
        if (nv_restore && wc_state_ok(nv_restore_state)) begin
            next_pers_state = nv_restore_state;
            next_wc_state   = nv_restore_state;
        end

        // Hard reset drops volatile changes
        // The SET FEATURES bit survives, only the feature state reverts
        if (hard_reset) begin
            next_wc_state = pers_state;
        end

        // SET FEATURES is always stored; forced states mask it
        if (setf_valid) begin
            next_setf_wce  = setf_enable;
            next_setf_done = 1'b1;
        end

        // Key sector command
        if (cmd_valid) begin
            // Abort answer first, a legal request overwrites it
            next_cmd_done      = 1'b1;
            next_tf_error      = ERR_ABORT;
            next_tf_status     = STAT_ERR;
            next_tf_sec_count  = TF_RESERVED;
            next_tf_sec_number = TF_RESERVED;
            // Only words 0 to 4 and option bit 0 are looked at
            if (key_action == ACTION_FEATURE_CTL && key_feature == FEAT_WRITE_CACHE) begin
                unique case (key_function)
                    FUNC_SET_STATE: begin
                        // Unknown states abort and change nothing
                        if (wc_state_ok(key_state)) begin
                            next_wc_state  = key_state;
                            next_tf_error  = ERR_OK;
                            next_tf_status = STAT_OK;
                            // Reload value and media copy move together
                            if (key_options[OPT_PERSIST_BIT]) begin
                                next_pers_state    = key_state;
                                next_nv_save       = 1'b1;
                                next_nv_save_state = key_state;
                            end
                        end
                    end
                    FUNC_GET_STATE: begin
                        // Reading never changes the state
                        next_tf_sec_count  = wc_state[7:0];
                        next_tf_sec_number = wc_state[15:8];
                        next_tf_error      = ERR_OK;
                        next_tf_status     = STAT_OK;
                    end
                    FUNC_GET_OPTIONS: begin
                        next_tf_sec_count  = OPT_FLAGS_WC[7:0];
                        next_tf_sec_number = OPT_FLAGS_WC[15:8];
                        next_tf_error      = ERR_OK;
                        next_tf_status     = STAT_OK;
                    end
                    default: begin
                        // Unknown function aborts
                        next_tf_error = ERR_ABORT;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************

    // Register all state, power-on reset restores defaults
    // nrst stands for a power cycle: the persistent copy
    // only comes back through a media restore
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wc_state      <= WC_DEFAULT;
            pers_state    <= WC_DEFAULT;
            setf_wce      <= SETF_WCE_DEFAULT;
            cmd_done      <= 1'b0;
            tf_error      <= ERR_OK;
            tf_sec_count  <= TF_RESERVED;
            tf_sec_number <= TF_RESERVED;
            tf_status     <= STAT_OK;
            setf_done     <= 1'b0;
            nv_save       <= 1'b0;
            nv_save_state <= WC_DEFAULT;
            cache_enable  <= SETF_WCE_DEFAULT;
        end else begin
            wc_state      <= next_wc_state;
            pers_state    <= next_pers_state;
            setf_wce      <= next_setf_wce;
            cmd_done      <= next_cmd_done;
            tf_error      <= next_tf_error;
            tf_sec_count  <= next_tf_sec_count;
            tf_sec_number <= next_tf_sec_number;
            tf_status     <= next_tf_status;
            setf_done     <= next_setf_done;
            nv_save       <= next_nv_save;
            nv_save_state <= next_nv_save_state;
            cache_enable  <= next_cache_enable;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // Identify word 85 carries the actual cache state in bit 5
    always_comb begin
        id_word85_mask                = 16'h0000;
        id_word85_mask[IDW85_WCE_BIT] = cache_enable;
    end

    // Current state for the host side and status logic
    assign wc_state_out = wc_state;

endmodule // feat_ctl_decoder

// ==== hdl/feat_ctl_pkg.sv ====
// Constants, codes and encodings for the feature control decoder
package feat_ctl_pkg;

    // ************************************************************
    // Key sector codes
    // ************************************************************
    localparam logic [15:0] ACTION_FEATURE_CTL = 16'h0004;  // Feature control action
    localparam logic [15:0] FUNC_SET_STATE     = 16'h0001;  // Set state
    localparam logic [15:0] FUNC_GET_STATE     = 16'h0002;  // Return state
    localparam logic [15:0] FUNC_GET_OPTIONS   = 16'h0003;  // Return option flags
    localparam logic [15:0] FEAT_WRITE_CACHE   = 16'h0001;  // Write cache control feature

    // ************************************************************
    // Write cache feature states
    // ************************************************************
    localparam logic [15:0] WC_BY_SETF    = 16'h0001;       // Governed by SET FEATURES
    localparam logic [15:0] WC_FORCE_ON   = 16'h0002;       // Forced enabled
    localparam logic [15:0] WC_FORCE_OFF  = 16'h0003;       // Forced disabled
    localparam logic [15:0] WC_DEFAULT    = WC_BY_SETF;     // State after power-up

    // ************************************************************
    // Option flags
    // ************************************************************
    localparam int          OPT_PERSIST_BIT = 0;            // Persist across power cycles
    localparam logic [15:0] OPT_FLAGS_WC    = 16'h0001;     // Flags reported for write cache

    // ************************************************************
    // Taskfile answers
    // ************************************************************
    localparam logic [7:0] ERR_OK      = 8'h00;             // Error on success
    localparam logic [7:0] STAT_OK     = 8'h50;             // Status on success
    localparam logic [7:0] ERR_ABORT   = 8'h04;             // Error on abort
    localparam logic [7:0] STAT_ERR    = 8'h51;             // Status on abort
    localparam logic [7:0] TF_RESERVED = 8'h00;             // Reserved fields read zero

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic SETF_WCE_DEFAULT = 1'b1;               // SET FEATURES cache enable at power-up
    localparam int   IDW85_WCE_BIT    = 5;                  // Identify word 85 cache bit

endpackage : feat_ctl_pkg

// ==== hdl/wc_policy.sv ====
// Write cache policy resolver: feature state against SET FEATURES
module wc_policy
    import feat_ctl_pkg::*;
(
    // Inputs
    input  wire logic [15:0] wc_state,   // Write cache feature state
    input  wire logic        setf_wce,   // Cache enable held by SET FEATURES
    // Output
    output logic             cache_on    // Resolved cache enable
);

    // ************************************************************
    // Resolution
    // ************************************************************

    // Forced states override the SET FEATURES setting
    always_comb begin
        unique case (wc_state)
            WC_FORCE_ON:  cache_on = 1'b1;
            WC_FORCE_OFF: cache_on = 1'b0;
            default:      cache_on = setf_wce;
        endcase
    end

endmodule // wc_policy

// ==== sim/feat_ctl_assertions.sv ====
// Concurrent checks on the feature control decoder ports
module feat_ctl_assertions
    import feat_ctl_pkg::*;
(
    // Clock, reset and state events
    input wire logic        clk, nrst, hard_reset, nv_restore,
    // Key sector request
    input wire logic        cmd_valid,
    input wire logic [15:0] key_action, key_function, key_feature, key_state, key_options,
    // Answers and cache state
    input wire logic        cmd_done, setf_valid, setf_enable, setf_done, nv_save, cache_enable,
    input wire logic [7:0]  tf_error, tf_sec_count, tf_sec_number, tf_status,
    input wire logic [15:0] nv_save_state, id_word85_mask, wc_state_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Request aimed at the write cache feature, and a legal set among them
    logic fc;
    logic set_ok;
    assign fc = cmd_valid && key_action == ACTION_FEATURE_CTL && key_feature == FEAT_WRITE_CACHE;
    assign set_ok = fc && key_function == FUNC_SET_STATE && key_state inside {WC_BY_SETF, WC_FORCE_ON, WC_FORCE_OFF};

    property p_take; cmd_valid |=> cmd_done; endproperty
    a_take: assert property (p_take) else $error("no answer one cycle after a key sector");
    property p_get; fc && key_function == FUNC_GET_STATE |=> {tf_error, tf_sec_count, tf_sec_number, tf_status}
        == {ERR_OK, $past(wc_state_out[7:0]), $past(wc_state_out[15:8]), STAT_OK}; endproperty
    a_get: assert property (p_get) else $error("state return answer wrong");
    property p_opt; fc && key_function == FUNC_GET_OPTIONS |=> {tf_error, tf_sec_count, tf_sec_number, tf_status}
        == {ERR_OK, OPT_FLAGS_WC[7:0], OPT_FLAGS_WC[15:8], STAT_OK}; endproperty
    a_opt: assert property (p_opt) else $error("option flags answer wrong");
    property p_set; set_ok |=> wc_state_out == $past(key_state) && tf_error == ERR_OK && tf_status == STAT_OK; endproperty
    a_set: assert property (p_set) else $error("set state not applied");
    property p_keep; set_ok && key_options[0] |=> nv_save && nv_save_state == $past(key_state); endproperty
    a_keep: assert property (p_keep) else $error("persistent set not saved");
    property p_vol; set_ok && !key_options[0] |=> !nv_save; endproperty
    a_vol: assert property (p_vol) else $error("volatile set was saved");
    property p_abort; cmd_valid && key_action != ACTION_FEATURE_CTL && !hard_reset && !nv_restore
        |=> tf_error == ERR_ABORT && tf_status == STAT_ERR && $stable(wc_state_out); endproperty
    a_abort: assert property (p_abort) else $error("foreign action not refused");
    property p_force; $past(wc_state_out) != WC_BY_SETF |-> cache_enable == ($past(wc_state_out) == WC_FORCE_ON); endproperty
    a_force: assert property (p_force) else $error("forced cache state not held");
    property p_gov; setf_valid ##1 wc_state_out == WC_BY_SETF |=> cache_enable == $past(setf_enable, 2); endproperty
    a_gov: assert property (p_gov) else $error("cache does not follow set features");
    property p_id; id_word85_mask == (16'(cache_enable) << IDW85_WCE_BIT); endproperty
    a_id: assert property (p_id) else $error("identify cache bit wrong");
    property p_dflt; $rose(nrst) |-> wc_state_out == WC_DEFAULT && cache_enable == SETF_WCE_DEFAULT; endproperty
    a_dflt: assert property (p_dflt) else $error("wrong state after reset");
    property p_setf; setf_valid |=> setf_done; endproperty
    a_setf: assert property (p_setf) else $error("set features not completed");
endmodule // feat_ctl_assertions

// ==== sim/sct_host_model.sv ====
// Host model that presents feature control key sectors
module sct_host_model (
    // Clock
    input  wire logic  clk,
    // Key sector words
    output logic        cmd_valid,
    output logic [15:0] key_action, key_function, key_feature, key_state, key_options
);
    timeunit 1ns;
    timeprecision 100ps;
    // Present one key sector, held until the taking edge has passed
    task automatic send(input logic [15:0] a, f, c, s, o);
        {key_action, key_function, key_feature, key_state, key_options} = {a, f, c, s, o};
        cmd_valid = 1'b1;
        @(posedge clk);
        #1;
    endtask
    // Release: stale words are inverted so nothing leans on old data
    task automatic idle();
        cmd_valid = 1'b0;
        {key_action, key_function, key_feature, key_state, key_options} =
            ~{key_action, key_function, key_feature, key_state, key_options};
    endtask
    // Quiet bus at time zero
    initial begin
        cmd_valid = 1'b0;
        {key_action, key_function, key_feature, key_state, key_options} = '0;
    end
endmodule // sct_host_model

// ==== sim/tb_feat_ctl_decoder.sv ====
// Self-checking bench for the feature control decoder
module tb_feat_ctl_decoder import feat_ctl_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, nrst, hard_reset, setf_valid, setf_enable, setf_done, nv_restore, nv_save;
    logic        cmd_valid, cmd_done, cache_enable, exp_wce;
    logic [15:0] key_action, key_function, key_feature, key_state, key_options;
    logic [15:0] nv_restore_state, nv_save_state, id_word85_mask, wc_state_out, exp_state, exp_persist;
    logic [7:0]  tf_error, tf_sec_count, tf_sec_number, tf_status;
    logic [31:0] exp_q[$];   // Expected taskfile answers, oldest first
    int          failures, cmp_count;

    feat_ctl_decoder feat_ctl_decoder_i (
        .clk(clk), .nrst(nrst), .hard_reset(hard_reset), .cmd_valid(cmd_valid),
        .key_action(key_action), .key_function(key_function), .key_feature(key_feature),
        .key_state(key_state), .key_options(key_options), .cmd_done(cmd_done),
        .tf_error(tf_error), .tf_sec_count(tf_sec_count), .tf_sec_number(tf_sec_number),
        .tf_status(tf_status), .setf_valid(setf_valid), .setf_enable(setf_enable),
        .setf_done(setf_done), .nv_restore(nv_restore), .nv_restore_state(nv_restore_state),
        .nv_save(nv_save), .nv_save_state(nv_save_state), .cache_enable(cache_enable),
        .id_word85_mask(id_word85_mask), .wc_state_out(wc_state_out)
    );
    sct_host_model sct_host_model_i (
        .clk(clk), .cmd_valid(cmd_valid), .key_action(key_action), .key_function(key_function),
        .key_feature(key_feature), .key_state(key_state), .key_options(key_options)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Compare one level or count
    task automatic chk_val(input string n, input logic [31:0] e, s);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    // Compare one taskfile answer
    task automatic chk_tf(input logic [31:0] e, s);
        chk_val("taskfile", e, s);
    endtask
    // Answer watcher: each answer pulse takes the oldest note
    always @(posedge clk) begin
        if (cmd_done === 1'b1) begin
            if (exp_q.size() == 0) chk_val("unexpected answer", 0, 1);
            else chk_tf(exp_q.pop_front(), {tf_error, tf_sec_count, tf_sec_number, tf_status});
        end
    end
    // Issue one key sector and note its answer
    task automatic cmd(input logic [15:0] a, f, c, s, o);
        logic ok;
        ok = a == ACTION_FEATURE_CTL && c == FEAT_WRITE_CACHE && f inside {[16'h0001:16'h0003]}
             && !(f == FUNC_SET_STATE && !(s inside {[16'h0001:16'h0003]}));
        if (!ok) exp_q.push_back({ERR_ABORT, 16'h0000, STAT_ERR});
        else if (f == FUNC_GET_STATE) exp_q.push_back({ERR_OK, exp_state[7:0], exp_state[15:8], STAT_OK});
        else if (f == FUNC_GET_OPTIONS) exp_q.push_back({ERR_OK, OPT_FLAGS_WC[7:0], OPT_FLAGS_WC[15:8], STAT_OK});
        else begin
            exp_q.push_back({ERR_OK, 16'h0000, STAT_OK});
            exp_state = s;
            if (o[0]) exp_persist = s;
        end
        sct_host_model_i.send(a, f, c, s, o);
    endtask
    // Write cache request through set features
    task automatic setf(input logic en);
        sct_host_model_i.idle();
        setf_valid = 1'b1;
        setf_enable = en;
        exp_wce = en;
        @(posedge clk);
        #1;
        setf_valid = 1'b0;
        chk_val("setf_done", 1, setf_done);
    endtask
    // Let things settle, then compare state, cache and identify bit
    task automatic check_state();
        logic c;
        sct_host_model_i.idle();
        repeat (3) @(posedge clk);
        #1;
        c = exp_state == WC_FORCE_ON || (exp_state == WC_BY_SETF && exp_wce);
        chk_val("wc_state_out", exp_state, wc_state_out);
        chk_val("cache_enable", c, cache_enable);
        chk_val("id_word85", 16'(c) << IDW85_WCE_BIT, id_word85_mask);
    endtask
    // Counts, verdict and end of run
    task automatic give_verdict();
        if (exp_q.size() != 0) chk_val("pending answers", 0, exp_q.size());
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog, far beyond the expected run
    initial begin
        #50000;
        failures++;
        give_verdict();
    end
    // Main sequence
    initial begin
        {nrst, hard_reset, setf_valid, setf_enable, nv_restore, nv_restore_state} = '0;
        {failures, cmp_count} = '0;
        {exp_state, exp_persist, exp_wce} = {WC_DEFAULT, WC_DEFAULT, SETF_WCE_DEFAULT};
        void'($urandom(46536));
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        check_state();
        // Each state set back to back, read back, flags asked, then the SET FEATURES bit flipped
        for (int s = 1; s <= 3; s++) begin
            cmd(ACTION_FEATURE_CTL, FUNC_SET_STATE, FEAT_WRITE_CACHE, 16'(s), 16'h0000);
            cmd(ACTION_FEATURE_CTL, FUNC_GET_STATE, FEAT_WRITE_CACHE, 16'h0000, 16'h0000);
            cmd(ACTION_FEATURE_CTL, FUNC_GET_OPTIONS, FEAT_WRITE_CACHE, 16'h0000, 16'h0000);
            setf(~exp_wce);
            check_state();
        end
        // Persistent set with junk reserved bits, volatile set, hard reset reverts
        cmd(ACTION_FEATURE_CTL, FUNC_SET_STATE, FEAT_WRITE_CACHE, WC_FORCE_OFF, {15'($urandom), 1'b1});
        cmd(ACTION_FEATURE_CTL, FUNC_SET_STATE, FEAT_WRITE_CACHE, WC_BY_SETF, 16'h0000);
        check_state();
        hard_reset = 1'b1;
        @(posedge clk);
        #1 hard_reset = 1'b0;
        exp_state = exp_persist;
        check_state();
        // Restore of a stored state from the media
        {nv_restore, nv_restore_state} = {1'b1, WC_FORCE_ON};
        @(posedge clk);
        #1 nv_restore = 1'b0;
        {exp_state, exp_persist} = {WC_FORCE_ON, WC_FORCE_ON};
        check_state();
        // Power cycle in mid-run: state, cache and persistent copy back to default
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        {exp_state, exp_persist, exp_wce} = {WC_DEFAULT, WC_DEFAULT, SETF_WCE_DEFAULT};
        check_state();
        // Refused requests back to back: action, feature, function, state
        cmd(16'h0003, FUNC_GET_STATE, FEAT_WRITE_CACHE, 16'h0000, 16'h0000);
        cmd(ACTION_FEATURE_CTL, FUNC_GET_STATE, 16'h0002, 16'h0000, 16'h0000);
        cmd(ACTION_FEATURE_CTL, 16'h0004, FEAT_WRITE_CACHE, 16'h0000, 16'h0000);
        cmd(ACTION_FEATURE_CTL, FUNC_SET_STATE, FEAT_WRITE_CACHE, 16'h0004, 16'h0000);
        check_state();
        // Random back-to-back traffic with random option words
        repeat (40) cmd(ACTION_FEATURE_CTL, 16'($urandom_range(1, 3)), FEAT_WRITE_CACHE,
                        16'($urandom_range(0, 4)), 16'($urandom));
        check_state();
        give_verdict();
    end
endmodule // tb_feat_ctl_decoder

bind feat_ctl_decoder feat_ctl_assertions feat_ctl_assertions_i (
    .clk(clk), .nrst(nrst), .hard_reset(hard_reset), .nv_restore(nv_restore), .cmd_valid(cmd_valid),
    .key_action(key_action), .key_function(key_function), .key_feature(key_feature),
    .key_state(key_state), .key_options(key_options), .cmd_done(cmd_done), .setf_valid(setf_valid),
    .setf_enable(setf_enable), .setf_done(setf_done), .nv_save(nv_save), .cache_enable(cache_enable),
    .tf_error(tf_error), .tf_sec_count(tf_sec_count), .tf_sec_number(tf_sec_number),
    .tf_status(tf_status), .nv_save_state(nv_save_state), .id_word85_mask(id_word85_mask),
    .wc_state_out(wc_state_out)
);
